// >>> inc/btg_pkg.sv
// Package of constants and types for the buzzer tone generator.
package btg_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CLOCK_CTRL  = 8'h00;
	localparam logic [7:0] OFS_TONE_CTRL   = 8'h04;
	localparam logic [7:0] OFS_TONE_SELECT = 8'h08;
	localparam logic [7:0] OFS_SOUND_BUF   = 8'h0C;
	localparam logic [7:0] OFS_FLAGS       = 8'h10;
	localparam logic [7:0] OFS_FLAG_CLEAR  = 8'h14;
	localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h18;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POS_CLOCK_SOURCE = 0;
	localparam int POS_CLOCK_DIVIDE = 4;
	localparam int POS_DEBUG_RUN    = 8;
	localparam int POS_MODULE_EN    = 0;
	localparam int POS_STOP         = 8;
	localparam int POS_OUTPUT_MODE  = 0;
	localparam int POS_PIN_DRIVE    = 8;
	localparam int POS_PERIOD       = 0;
	localparam int POS_HIGH_LEN     = 8;
	localparam int POS_EMPTY_FLAG   = 0;
	localparam int POS_DONE_FLAG    = 1;
	localparam int POS_BUSY_FLAG    = 2;

	// ----------------------------------------------------------------
	// Widths, reset values and modes
	// ----------------------------------------------------------------
	localparam int PERIOD_W = 8;
	localparam int LEN_W    = 6;
	localparam int IRQ_W    = 2;
	localparam logic [1:0] MODE_NORMAL         = 2'h0;
	localparam logic [1:0] RST_CLOCK_SOURCE    = 2'h0;
	localparam logic [2:0] RST_CLOCK_DIVIDE    = 3'h0;
	localparam logic [1:0] RST_OUTPUT_MODE     = 2'h0;
	localparam logic [IRQ_W-1:0] RST_IRQ_EN    = 2'h0;

	// ----------------------------------------------------------------
	// Timing: bus clock and nominal tone operating clock
	// ----------------------------------------------------------------
	localparam int HCLK_HZ     = 25000000;
	localparam int OPCLK_HZ    = 32768;
	localparam int TICK_CYCLES = HCLK_HZ / OPCLK_HZ;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [LEN_W-1:0]    high_length_field;
		logic [PERIOD_W-1:0] period_field;
	} btg_sound_t;

	typedef struct packed {
		logic busy_flag;
		logic output_done_flag;
		logic buffer_empty_flag;
	} btg_flags_t;

endpackage

// >>> rtl/btg_sync.sv
// Two-flop synchroniser for a group of level inputs.
module btg_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stage_one <= '0;
			sync_out  <= '0;
		end
		else
		begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end

endmodule

// >>> rtl/btg_tone.sv
// Tone period counter that yields the high phase of each tone cycle.
module btg_tone
	import btg_pkg::*;
(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Control
	input  wire logic       op_tick,
	input  wire logic       load,
	input  wire logic       run,
	input  wire btg_sound_t sound,
	// Result
	output logic            tone_high
);

	logic [PERIOD_W-1:0] count;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count <= '0;
		else if (load)
			count <= '0;
		else if (op_tick && run)
		begin
			if (count == sound.period_field)
				count <= '0;
			else
				count <= count + 8'h01;
		end
	end

	// High for counts 0..length, so length plus one operating cycles.
	assign tone_high = run && (count <= {2'h0, sound.high_length_field});

endmodule

// >>> rtl/btg_top.sv
// Buzzer tone generator with AHB-Lite register slave and interrupt.

module btg_top
	import btg_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Power state inputs from outside the clock domain
	input  wire logic        cpu_sleep,
	input  wire logic        cpu_debug,
	input  wire logic        source_sleep_stop,
	// Buzzer pins and interrupt
	output logic             tone_pin_true,
	output logic             tone_pin_complement,
	output logic             irq
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (TICK_DIV < 2 || TICK_DIV > 65536)
	begin : g_bad_div
		$error("TICK_DIV must lie between 2 and 65536");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [1:0]           clock_source_field;
	logic [2:0]           clock_divide_field;
	logic                 debug_run_bit;
	logic                 module_enable_bit;
	logic [1:0]           output_mode_field;
	logic                 pin_drive_select;
	btg_sound_t           sound_buffer;
	btg_sound_t           sound_work;
	btg_flags_t           flag_register;
	logic [IRQ_W-1:0]     irq_enable_register;
	logic                 pending;
	logic                 running;
	logic [2:0]           power_sync;
	logic                 halted;
	logic [15:0]          pre_cnt;
	logic [6:0]           div_cnt;
	logic [6:0]           div_mask;
	logic                 base_tick;
	logic                 op_tick;
	logic                 load;
	logic                 tone_high;
	logic                 addr_valid;
	logic                 wr_pend;
	logic [7:0]           wr_addr;
	logic                 wr_clock;
	logic                 wr_ctrl;
	logic                 wr_select;
	logic                 wr_buf;
	logic                 wr_clear;
	logic                 wr_enable;
	logic                 stop_req;
	logic                 start_req;
	logic [31:0]          next_rdata;

	// ----------------------------------------------------------------
	// Power state synchronisation and halt
	// ----------------------------------------------------------------
	btg_sync #(
		.WIDTH (3)
	) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in ({source_sleep_stop, cpu_debug, cpu_sleep}),
		.sync_out (power_sync)
	);

	// While halted no operating tick is made, so the tone counter,
	// the pending load and the pins all hold their state.
	assign halted = (power_sync[0] && power_sync[2])
		|| (power_sync[1] && !debug_run_bit);

	// ----------------------------------------------------------------
	// Operating clock tick
	// ----------------------------------------------------------------
	// The operating clock is a tick on hclk near the nominal rate; the
	// divide field slows it by a power of two. All sources share this
	// one reference, so the source field is only held for software.
	assign base_tick = (pre_cnt == 16'(TICK_DIV - 1));
	assign div_mask  = 7'((8'h01 << clock_divide_field) - 8'h01);
	assign op_tick   = base_tick && ((div_cnt & div_mask) == div_mask)
		&& !halted && module_enable_bit;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pre_cnt <= '0;
		else if (halted)
			pre_cnt <= pre_cnt;
		else if (base_tick)
			pre_cnt <= '0;
		else
			pre_cnt <= pre_cnt + 16'h0001;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			div_cnt <= '0;
		else if (base_tick && !halted)
			div_cnt <= div_cnt + 7'h01;
	end

	// ----------------------------------------------------------------
	// AHB-Lite address and data phase
	// ----------------------------------------------------------------
	// Zero wait state slave: every transfer completes OKAY at once.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_valid = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else
		begin
			wr_pend <= addr_valid && hwrite && (haddr[31:8] == 24'h000000);
			wr_addr <= haddr[7:0];
		end
	end

	assign wr_clock  = wr_pend && (wr_addr == OFS_CLOCK_CTRL);
	assign wr_ctrl   = wr_pend && (wr_addr == OFS_TONE_CTRL);
	assign wr_select = wr_pend && (wr_addr == OFS_TONE_SELECT);
	assign wr_buf    = wr_pend && (wr_addr == OFS_SOUND_BUF);
	assign wr_clear  = wr_pend && (wr_addr == OFS_FLAG_CLEAR);
	assign wr_enable = wr_pend && (wr_addr == OFS_IRQ_ENABLE);
	assign stop_req  = wr_ctrl && hwdata[POS_STOP];
	assign start_req = wr_buf && module_enable_bit
		&& (output_mode_field == MODE_NORMAL);

	// ----------------------------------------------------------------
	// Read data, registered at the address phase
	// ----------------------------------------------------------------
	always_comb
	begin
		next_rdata = 32'h00000000;
		if (haddr[31:8] == 24'h000000)
		begin
			case (haddr[7:0])
				OFS_CLOCK_CTRL:
				begin
					next_rdata[POS_CLOCK_SOURCE +: 2] = clock_source_field;
					next_rdata[POS_CLOCK_DIVIDE +: 3] = clock_divide_field;
					next_rdata[POS_DEBUG_RUN]         = debug_run_bit;
				end
				OFS_TONE_CTRL:
					next_rdata[POS_MODULE_EN] = module_enable_bit;
				OFS_TONE_SELECT:
				begin
					next_rdata[POS_OUTPUT_MODE +: 2] = output_mode_field;
					next_rdata[POS_PIN_DRIVE]        = pin_drive_select;
				end
				OFS_SOUND_BUF:
				begin
					next_rdata[POS_PERIOD +: PERIOD_W] = sound_buffer.period_field;
					next_rdata[POS_HIGH_LEN +: LEN_W]  = sound_buffer.high_length_field;
				end
				OFS_FLAGS:
					next_rdata[2:0] = flag_register;
				OFS_IRQ_ENABLE:
					next_rdata[IRQ_W-1:0] = irq_enable_register;
				default:
					next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (addr_valid && !hwrite)
			hrdata <= next_rdata;
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			clock_source_field <= RST_CLOCK_SOURCE;
			clock_divide_field <= RST_CLOCK_DIVIDE;
			debug_run_bit      <= 1'b0;
		end
		else if (wr_clock)
		begin
			clock_source_field <= hwdata[POS_CLOCK_SOURCE +: 2];
			clock_divide_field <= hwdata[POS_CLOCK_DIVIDE +: 3];
			debug_run_bit      <= hwdata[POS_DEBUG_RUN];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			module_enable_bit <= 1'b0;
		else if (wr_ctrl)
			module_enable_bit <= hwdata[POS_MODULE_EN];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			output_mode_field <= RST_OUTPUT_MODE;
			pin_drive_select  <= 1'b0;
		end
		else if (wr_select)
		begin
			output_mode_field <= hwdata[POS_OUTPUT_MODE +: 2];
			pin_drive_select  <= hwdata[POS_PIN_DRIVE];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_enable_register <= RST_IRQ_EN;
		else if (wr_enable)
			irq_enable_register <= hwdata[IRQ_W-1:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sound_buffer <= '0;
		else if (wr_buf)
		begin
			sound_buffer.period_field      <= hwdata[POS_PERIOD +: PERIOD_W];
			sound_buffer.high_length_field <= hwdata[POS_HIGH_LEN +: LEN_W];
		end
	end

	// ----------------------------------------------------------------
	// Buffer load and output sequencing
	// ----------------------------------------------------------------
	// The buffer moves into the working register only on an operating
	// tick, so a write that lands mid-period takes effect cleanly.
	assign load = pending && op_tick;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pending <= 1'b0;
		else if (!module_enable_bit || stop_req)
			pending <= 1'b0;
		else if (start_req)
			pending <= 1'b1;
		else if (load)
			pending <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sound_work <= '0;
		else if (load)
			sound_work <= sound_buffer;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			running <= 1'b0;
		else if (!module_enable_bit || stop_req)
			running <= 1'b0;
		else if (load)
			running <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Flags and interrupt
	// ----------------------------------------------------------------
	// A hardware set in the same cycle as a software clear wins.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flag_register.buffer_empty_flag <= 1'b1;
		else if (load)
			flag_register.buffer_empty_flag <= 1'b1;
		else if (start_req)
			flag_register.buffer_empty_flag <= 1'b0;
		else if (wr_clear && hwdata[POS_EMPTY_FLAG])
			flag_register.buffer_empty_flag <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flag_register.output_done_flag <= 1'b0;
		else if (stop_req && module_enable_bit)
			flag_register.output_done_flag <= 1'b1;
		else if (wr_clear && hwdata[POS_DONE_FLAG])
			flag_register.output_done_flag <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flag_register.busy_flag <= 1'b0;
		else if (!module_enable_bit || stop_req)
			flag_register.busy_flag <= 1'b0;
		else if (load)
			flag_register.busy_flag <= 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |({flag_register.output_done_flag,
				flag_register.buffer_empty_flag} & irq_enable_register);
	end

	// ----------------------------------------------------------------
	// Tone waveform and pin drive
	// ----------------------------------------------------------------
	btg_tone u_tone (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.op_tick   (op_tick),
		.load      (load),
		.run       (running),
		.sound     (sound_work),
		.tone_high (tone_high)
	);

	// Pins update only when not halted, so a frozen block holds them.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tone_pin_true       <= 1'b0;
			tone_pin_complement <= 1'b0;
		end
		else if (!halted)
		begin
			tone_pin_true <= tone_high;
			if (pin_drive_select)
				tone_pin_complement <= !tone_high;
			else
				tone_pin_complement <= running && !tone_high;
		end
	end

endmodule

// >>> verif/btg_properties.sv
// Port-level assertion checker for the buzzer tone generator, bound to its top module.
module btg_checker
	import btg_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	// Power state, pins and interrupt
	input wire logic        cpu_sleep,
	input wire logic        cpu_debug,
	input wire logic        source_sleep_stop,
	input wire logic        tone_pin_true,
	input wire logic        tone_pin_complement,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        dp_wr;
	logic [7:0]  dp_ofs;
	logic [31:0] r_clk, r_ctl, r_sel, r_buf, r_ien;
	logic        pin_d, clean, halt, dirty, wr_stop, wr_go, wr_clr;
	int          ph_cnt, tick_len;

	assign halt = (cpu_debug && !r_clk[POS_DEBUG_RUN]) || (cpu_sleep && source_sleep_stop);
	assign dirty = halt || (dp_wr && dp_ofs <= OFS_SOUND_BUF);
	assign tick_len = TICK_DIV << r_clk[6:4];
	assign wr_stop = dp_wr && dp_ofs == OFS_TONE_CTRL && hwdata[POS_STOP];
	assign wr_clr = dp_wr && dp_ofs == OFS_FLAG_CLEAR;
	assign wr_go = dp_wr && dp_ofs == OFS_SOUND_BUF && r_ctl[POS_MODULE_EN] && r_sel[1:0] == MODE_NORMAL;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_wr  <= 1'b0;
			dp_ofs <= 8'h00;
		end
		else if (hready)
		begin
			dp_wr  <= hsel && htrans[1] && hwrite && haddr[31:8] == 24'h000000;
			dp_ofs <= haddr[7:0];
		end
	end

	// Shadow copies of the written registers give the expected figures.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r_clk <= 32'h00000000;
			r_ctl <= 32'h00000000;
			r_sel <= 32'h00000000;
			r_buf <= 32'h00000000;
			r_ien <= 32'h00000000;
		end
		else if (dp_wr)
		begin
			if (dp_ofs == OFS_CLOCK_CTRL)
				r_clk <= hwdata;
			if (dp_ofs == OFS_TONE_CTRL)
				r_ctl <= hwdata;
			if (dp_ofs == OFS_TONE_SELECT)
				r_sel <= hwdata;
			if (dp_ofs == OFS_SOUND_BUF)
				r_buf <= hwdata;
			if (dp_ofs == OFS_IRQ_ENABLE)
				r_ien <= hwdata;
		end
	end

	// A tone cycle is judged only if no halt and no write to an offset up to the sound buffer touched it since it began.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_d  <= 1'b0;
			ph_cnt <= 0;
			clean  <= 1'b0;
		end
		else
		begin
			pin_d  <= tone_pin_true;
			ph_cnt <= (tone_pin_true && !pin_d) ? 1 : ph_cnt + 1;
			clean  <= (tone_pin_true && !pin_d) ? !dirty : clean && !dirty;
		end
	end

	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_direct_off;
		wr_stop && !r_sel[POS_PIN_DRIVE] && !halt |-> ##2 !tone_pin_true && !tone_pin_complement;
	endproperty
	a_direct_off: assert property (p_direct_off) else $error("pins not low after stop");
	property p_complement;
		r_sel[POS_PIN_DRIVE] && $past(r_sel[POS_PIN_DRIVE]) |-> tone_pin_complement != tone_pin_true;
	endproperty
	a_complement: assert property (p_complement) else $error("complement pin wrong");
	property p_irq_gate;
		irq |-> $past(r_ien[1:0]) != 2'h0;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
	property p_clear_drop;
		wr_clr && hwdata[POS_DONE_FLAG] && r_ien[1:0] == 2'h2 |-> ##2 !irq;
	endproperty
	a_clear_drop: assert property (p_clear_drop) else $error("irq stays after clear");
	property p_stop_done;
		wr_stop && r_ien[POS_DONE_FLAG] |-> ##2 irq;
	endproperty
	a_stop_done: assert property (p_stop_done) else $error("no done irq after stop");
	property p_go_empty;
		wr_go && r_ien[1:0] == 2'h1 |-> ##2 !irq ##[1:600] irq;
	endproperty
	a_go_empty: assert property (p_go_empty) else $error("empty flag sequence wrong");
	property p_high;
		$fell(tone_pin_true) && clean && !dirty |-> ph_cnt == (int'(r_buf[13:8]) + 1) * tick_len;
	endproperty
	a_high: assert property (p_high) else $error("high time wrong");
	property p_period;
		$rose(tone_pin_true) && clean && !dirty |-> ph_cnt == (int'(r_buf[7:0]) + 1) * tick_len;
	endproperty
	a_period: assert property (p_period) else $error("tone period wrong");
	property p_freeze_dbg;
		(cpu_debug && !r_clk[POS_DEBUG_RUN]) [*4] |-> $stable(tone_pin_true) && $stable(tone_pin_complement);
	endproperty
	a_freeze_dbg: assert property (p_freeze_dbg) else $error("pins move in debug");
	property p_freeze_slp;
		(cpu_sleep && source_sleep_stop) [*4] |-> $stable(tone_pin_true) && $stable(tone_pin_complement);
	endproperty
	a_freeze_slp: assert property (p_freeze_slp) else $error("pins move in sleep");

	c_stop: cover property (wr_stop);
	c_cycle: cover property ($rose(tone_pin_true) && clean);
	c_irq_drop: cover property ($fell(irq));
endmodule

bind btg_top btg_checker #(.TICK_DIV(TICK_DIV)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .cpu_sleep(cpu_sleep), .cpu_debug(cpu_debug),
	.source_sleep_stop(source_sleep_stop), .tone_pin_true(tone_pin_true),
	.tone_pin_complement(tone_pin_complement), .irq(irq));

// >>> verif/btg_buzzer.sv
// Behavioural piezo buzzer that measures the differential drive across its two pins.
module btg_buzzer (
	// Clock
	input wire logic hclk,
	// Buzzer pins
	input wire logic tone_pin_true,
	input wire logic tone_pin_complement,
	// Rise count and lengths in clock cycles
	output int       rises,
	output int       hi_len,
	output int       per_len
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pos = 1'b0;
	int   cnt = 0;

	initial
	begin
		rises = 0;
		hi_len = 0;
		per_len = 0;
	end

	// Outputs update by non-blocking assignment so readers at the same edge see stable values.
	always @(posedge hclk)
	begin
		cnt = cnt + 1;
		if (tone_pin_true && !tone_pin_complement && !pos)
		begin
			per_len <= cnt;
			rises <= rises + 1;
			cnt = 0;
		end
		if (!(tone_pin_true && !tone_pin_complement) && pos)
			hi_len <= cnt;
		pos = tone_pin_true && !tone_pin_complement;
	end
endmodule

// >>> verif/tb.sv
// Self-checking testbench for the buzzer tone generator.
module tb
	import btg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TD = 4;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic        hreadyout, hresp, pin_t, pin_c, irq;
	logic        cpu_sleep = 1'b0;
	logic        cpu_debug = 1'b0;
	logic        slp_stop = 1'b0;
	int          err_count = 0;
	int          total_checks = 0;
	int          rises, hi_len, per_len;

	always #20 hclk = ~hclk;

	btg_top #(.TICK_DIV(TD)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_sleep(cpu_sleep),
		.cpu_debug(cpu_debug), .source_sleep_stop(slp_stop), .tone_pin_true(pin_t),
		.tone_pin_complement(pin_c), .irq(irq));
	btg_buzzer u_bz (.hclk(hclk), .tone_pin_true(pin_t), .tone_pin_complement(pin_c),
		.rises(rises), .hi_len(hi_len), .per_len(per_len));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// Bounded wait for a number of tone rises seen by the buzzer, or with ready set for hreadyout.
	task automatic wait_edges(input int n, input bit ready);
		int k, start;
		k = 0;
		start = rises;
		do
		begin
			@(posedge hclk);
			k++;
		end
		while ((ready ? hreadyout !== 1'b1 : rises < start + n) && k < 5000);
		if (k >= 5000)
		begin
			err_count++;
			print_verdict();
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
		haddr <= {24'h0, ofs};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_edges(0, 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		wait_edges(0, 1'b1);
		rd = hrdata;
	endtask

	task automatic rchk(input string name, input logic [7:0] ofs, input logic [31:0] exp);
		ahb(1'b0, ofs, 32'h0);
		check(name, rd, exp);
	endtask

	task automatic t_reset_init();
		rchk("flags reset", OFS_FLAGS, 32'h1);
		rchk("unmapped", 8'h40, 32'h0);
		check("okay", hresp, 1'b0);
		ahb(1'b1, OFS_SOUND_BUF, 32'h0103);
		repeat (3 * TD) @(posedge hclk);
		rchk("flags disabled", OFS_FLAGS, 32'h1);
		ahb(1'b1, OFS_CLOCK_CTRL, 32'h0);
		ahb(1'b1, OFS_TONE_CTRL, 32'h1);
		ahb(1'b1, OFS_TONE_SELECT, 32'h0);
		ahb(1'b1, OFS_FLAG_CLEAR, 32'h3);
		rchk("flags cleared", OFS_FLAGS, 32'h0);
		ahb(1'b1, OFS_TONE_SELECT, 32'h1);
		ahb(1'b1, OFS_SOUND_BUF, 32'h0103);
		repeat (3 * TD) @(posedge hclk);
		rchk("flags other mode", OFS_FLAGS, 32'h0);
		ahb(1'b1, OFS_TONE_SELECT, 32'h0);
		ahb(1'b1, OFS_IRQ_ENABLE, 32'h1);
		repeat (2) @(posedge hclk);
		check("irq idle", irq, 1'b0);
	endtask

	task automatic t_tone(input logic [7:0] per, input logic [5:0] len, input logic drv,
		input logic [2:0] div);
		int tl;
		tl = TD << div;
		ahb(1'b1, OFS_CLOCK_CTRL, {24'h0, 1'b0, div, 4'h0});
		ahb(1'b1, OFS_TONE_SELECT, {23'h0, drv, 8'h0});
		ahb(1'b1, OFS_SOUND_BUF, {18'h0, len, per});
		wait_edges(3, 1'b0);
		check("high", hi_len, (len + 1) * tl);
		check("period", per_len, (per + 1) * tl);
		rchk("flags run", OFS_FLAGS, 32'h5);
		ahb(1'b1, OFS_TONE_CTRL, 32'h101);
		rchk("flags stop", OFS_FLAGS, 32'h3);
		repeat (2) @(posedge hclk);
		check("pin true off", pin_t, 1'b0);
		check("pin comp off", pin_c, drv);
		ahb(1'b1, OFS_FLAG_CLEAR, 32'h3);
	endtask

	task automatic t_irq();
		ahb(1'b1, OFS_IRQ_ENABLE, 32'h2);
		ahb(1'b1, OFS_SOUND_BUF, 32'h0103);
		wait_edges(1, 1'b0);
		check("irq masked", irq, 1'b0);
		ahb(1'b1, OFS_TONE_CTRL, 32'h101);
		repeat (2) @(posedge hclk);
		check("irq done", irq, 1'b1);
		ahb(1'b1, OFS_FLAG_CLEAR, 32'h2);
		repeat (2) @(posedge hclk);
		check("irq cleared", irq, 1'b0);
		ahb(1'b1, OFS_IRQ_ENABLE, 32'h0);
	endtask

	// Holds debug or sleep for a while; with the run bit clear the pins must not move.
	task automatic t_freeze(input logic run, input logic slp);
		logic a, b;
		int r0;
		ahb(1'b1, OFS_CLOCK_CTRL, {23'h0, run, 8'h0});
		ahb(1'b1, OFS_SOUND_BUF, 32'h0307);
		wait_edges(2, 1'b0);
		cpu_debug <= !slp;
		cpu_sleep <= slp;
		slp_stop <= slp;
		repeat (4) @(posedge hclk);
		a = pin_t;
		b = pin_c;
		r0 = rises;
		repeat (100) @(posedge hclk);
		check("running", rises != r0, run);
		check("held true", run ? hi_len : pin_t, run ? 32'(4 * TD) : a);
		check("held comp", run ? per_len : pin_c, run ? 32'(8 * TD) : b);
		rchk("kept setting", OFS_CLOCK_CTRL, {23'h0, run, 8'h0});
		cpu_debug <= 1'b0;
		cpu_sleep <= 1'b0;
		slp_stop <= 1'b0;
		wait_edges(2, 1'b0);
		ahb(1'b1, OFS_TONE_CTRL, 32'h101);
		ahb(1'b1, OFS_FLAG_CLEAR, 32'h3);
	endtask

	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_init();
		t_tone(8'h01, 6'h00, 1'b0, 3'h0);
		t_tone(8'h07, 6'h06, 1'b1, 3'h1);
		t_tone(8'h03, 6'h02, 1'b0, 3'h2);
		t_irq();
		t_freeze(1'b0, 1'b0);
		t_freeze(1'b1, 1'b0);
		t_freeze(1'b0, 1'b1);
		print_verdict();
	end
endmodule
